//--- eeprom_bus_framing.sv
// Two-wire bus framing for a serial memory target
// Behaviour
// - Data may change only while the bus clock is low, and is held through every clock-high phase.
// - A data change while the bus clock is high is a start or stop, never a data bit.
// - Data falling with clock high is a start, which opens every transaction.
// - Data rising with clock high is a stop, detected at any point outside the write cycle.
// - A stop ending a read returns the block to standby to wait for a start.
// - Every word is eight bits, one bit per clock pulse.
// - Each received word is acknowledged by holding data low for the whole ninth pulse.
// - Standby is entered at power-up and after a stop once internal work is done.
// - The internal write cycle runs from the stop ending a write, lasting 20, 10 or 5 ms by grade.
// - Data is sampled on rising clock edges and changed on falling clock edges.
// - During the write cycle all bus inputs are ignored and no acknowledge is given.
// - After a start comes an eight-bit address word whose last bit high means read.
`timescale 1ns/1ps
`include "eeprom_bus_defs.svh"
module eeprom_bus_framing (
    // Clock, reset and enable
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Write cycle grade
    input wire eeprom_bus_pkg::wr_grade_t grade_in,
    // Received words
    output logic word_valid_out,
    output eeprom_bus_pkg::rx_word_t word_out,
    input wire logic word_ready_in,
    // Status
    output eeprom_bus_pkg::bus_status_t status_out,
    output logic start_seen_out,
    output logic stop_seen_out,
    output logic overflow_out
);
    import eeprom_bus_pkg::*;

    // ****************************************
    // Input synchronisers and glitch filters
    // ****************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [2:0] scl_cnt;
    logic [2:0] sda_cnt;
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else if (enable_in) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            scl_cnt <= 3'h0;
            sda_cnt <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else if (enable_in) begin
            if (scl_sync[1] == scl_f) begin
                scl_cnt <= 3'h0;
            end else if (scl_cnt == `GLITCH_CYCLES) begin
                scl_f <= scl_sync[1];
                scl_cnt <= 3'h0;
            end else begin
                scl_cnt <= scl_cnt + 3'h1;
            end
            if (sda_sync[1] == sda_f) begin
                sda_cnt <= 3'h0;
            end else if (sda_cnt == `GLITCH_CYCLES) begin
                sda_f <= sda_sync[1];
                sda_cnt <= 3'h0;
            end else begin
                sda_cnt <= sda_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (enable_in) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // ****************************************
    // Edge and condition detection
    // ****************************************
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_det = scl_f && scl_q && sda_q && !sda_f;
    assign stop_det = scl_f && scl_q && !sda_q && sda_f;

    // ****************************************
    // Framing state machine
    // ****************************************
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic first_word;
    logic is_read;
    logic wrote;
    logic [31:0] wr_cnt;
    logic [31:0] wr_limit;
    logic fifo_ready;
    logic push;

    always_comb begin
        case (grade_in)
            GRADE_SLOW: wr_limit = 32'(`WR_CYCLES_SLOW);
            GRADE_FAST: wr_limit = 32'(`WR_CYCLES_FAST);
            default: wr_limit = 32'(`WR_CYCLES_STD);
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state <= ST_STANDBY;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            first_word <= 1'b0;
            is_read <= 1'b0;
            wrote <= 1'b0;
            wr_cnt <= 32'h0;
            push <= 1'b0;
        end else if (enable_in) begin
            push <= 1'b0;
            case (state)
                ST_WRITE_CYCLE: begin
                    if (wr_cnt >= wr_limit - 32'h1) begin
                        state <= ST_STANDBY;
                        wr_cnt <= 32'h0;
                    end else begin
                        wr_cnt <= wr_cnt + 32'h1;
                    end
                end
                default: begin
                    if (stop_det) begin
                        state <= (wrote && !is_read) ? ST_WRITE_CYCLE : ST_STANDBY;
                        wrote <= 1'b0;
                        wr_cnt <= 32'h0;
                    end else if (start_det) begin
                        state <= ST_RECEIVE;
                        bit_cnt <= 4'h0;
                        first_word <= 1'b1;
                        is_read <= 1'b0;
                        wrote <= 1'b0;
                    end else if (state == ST_RECEIVE && scl_rise) begin
                        shift <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `WORD_BITS - 4'h1) begin
                            state <= ST_ACK;
                            push <= 1'b1;
                            if (first_word) begin
                                is_read <= sda_f;
                            end else begin
                                wrote <= 1'b1;
                            end
                        end
                    end else if (state == ST_ACK && scl_fall && bit_cnt == `ACK_BIT_INDEX) begin
                        state <= is_read ? ST_IGNORE : ST_RECEIVE;
                        bit_cnt <= 4'h0;
                        first_word <= 1'b0;
                    end else if (state == ST_ACK && scl_rise) begin
                        bit_cnt <= `ACK_BIT_INDEX;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Data line driver
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sda_oe_out <= 1'b0;
            sda_out <= 1'b1;
        end else if (enable_in) begin
            sda_out <= 1'b0;
            if (state == ST_ACK && scl_fall && bit_cnt == `WORD_BITS) begin
                sda_oe_out <= 1'b1;
            end else if (state != ST_ACK || (scl_fall && bit_cnt == `ACK_BIT_INDEX)) begin
                sda_oe_out <= 1'b0;
            end
        end
    end

    // ****************************************
    // Word buffer and status
    // ****************************************
    logic fifo_valid;
    rx_word_t fifo_data;

    word_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .enable_in(enable_in),
        .in_valid_in(push),
        .in_data_in({first_word, shift}),
        .in_ready_out(fifo_ready),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(word_ready_in && word_valid_out)
    );

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            word_valid_out <= 1'b0;
            word_out <= '0;
            status_out <= 3'h1;
            start_seen_out <= 1'b0;
            stop_seen_out <= 1'b0;
            overflow_out <= 1'b0;
        end else if (enable_in) begin
            word_valid_out <= fifo_valid && !(word_ready_in && word_valid_out);
            word_out <= fifo_data;
            status_out.in_frame <= (state == ST_RECEIVE) || (state == ST_ACK) || (state == ST_IGNORE);
            status_out.write_busy <= (state == ST_WRITE_CYCLE);
            status_out.standby <= (state == ST_STANDBY);
            start_seen_out <= start_det && state != ST_WRITE_CYCLE;
            stop_seen_out <= stop_det && state != ST_WRITE_CYCLE;
            overflow_out <= push && !fifo_ready;
        end
    end
endmodule

//--- eeprom_bus_defs.svh
// Offsets, field positions and timing counts for the two-wire framing block
`ifndef EEPROM_BUS_DEFS_SVH
`define EEPROM_BUS_DEFS_SVH

`define CLK_FREQ_KHZ 25000
`define WORD_BITS 4'h8
`define ACK_BIT_INDEX 4'h9
`define RW_BIT_POS 0
`define WR_TIME_MS_SLOW 20
`define WR_TIME_MS_STD 10
`define WR_TIME_MS_FAST 5
`define WR_CYCLES_SLOW (`WR_TIME_MS_SLOW * `CLK_FREQ_KHZ)
`define WR_CYCLES_STD (`WR_TIME_MS_STD * `CLK_FREQ_KHZ)
`define WR_CYCLES_FAST (`WR_TIME_MS_FAST * `CLK_FREQ_KHZ)
`define GLITCH_CYCLES 3'h1
`define FIFO_DEPTH 32

`endif

//--- eeprom_bus_pkg.sv
// Types shared by the two-wire framing block
package eeprom_bus_pkg;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_RECEIVE = 3'h1,
        ST_ACK = 3'h3,
        ST_IGNORE = 3'h2,
        ST_WRITE_CYCLE = 3'h6
    } bus_state_t;

    typedef enum logic [1:0] {
        GRADE_SLOW = 2'h0,
        GRADE_STD = 2'h1,
        GRADE_FAST = 2'h2
    } wr_grade_t;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } rx_word_t;

    typedef struct packed {
        logic in_frame;
        logic write_busy;
        logic standby;
    } bus_status_t;

endpackage

//--- word_fifo.sv
// Valid/ready FIFO buffering received words
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and control
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;
    logic full;
    logic empty;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;
    assign next_wr_ptr = wr_ptr + (AW+1)'(1);
    assign next_rd_ptr = rd_ptr + (AW+1)'(1);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (enable_in && push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (enable_in) begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
        end
    end
endmodule

//--- eeprom_bus_framing_chk.sv
// Port checks for the two-wire framing block
`timescale 1ns/1ps
module eeprom_bus_framing_chk (
    // Clock and control
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // Bus pins and write cycle grade
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire eeprom_bus_pkg::wr_grade_t grade_in,
    // Words and status
    input wire logic word_valid_out,
    input wire eeprom_bus_pkg::rx_word_t word_out,
    input wire logic word_ready_in,
    input wire eeprom_bus_pkg::bus_status_t status_out,
    input wire logic start_seen_out,
    input wire logic stop_seen_out,
    input wire logic overflow_out
);
    import eeprom_bus_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_ack_low: assert property (sda_oe_out |-> !sda_out && status_out.in_frame) else $error("stray ack");
    a_ack_held: assert property ($rose(sda_oe_out) |-> sda_oe_out [*4]) else $error("short ack");
    a_start_ok: assert property (start_seen_out |-> scl_in && !sda_in) else $error("bad start");
    a_stop_ok: assert property (stop_seen_out |-> scl_in && sda_in) else $error("bad stop");
    a_stop_rest: assert property (stop_seen_out |-> ##[0:2] (status_out.standby || status_out.write_busy))
        else $error("no rest");
    a_busy_deaf: assert property (status_out.write_busy |-> !sda_oe_out && !start_seen_out) else $error("busy");
    a_take_drop: assert property (word_valid_out && word_ready_in |=> !word_valid_out) else $error("held");
    a_standby_only: assert property (status_out.standby |-> !status_out.in_frame && !status_out.write_busy)
        else $error("standby mix");
    a_ack_edge: assert property ($changed(sda_oe_out) |-> !$past(scl_in)) else $error("ack edge");
    a_start_opens: assert property ($rose(status_out.in_frame) |-> $past(start_seen_out))
        else $error("no start");
endmodule
bind eeprom_bus_framing eeprom_bus_framing_chk chk (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(enable_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .grade_in(grade_in),
    .word_valid_out(word_valid_out), .word_out(word_out), .word_ready_in(word_ready_in), .status_out(status_out),
    .start_seen_out(start_seen_out), .stop_seen_out(stop_seen_out), .overflow_out(overflow_out));

//--- bus_host_model.sv
// Bus host model driving the link clock and pulling the data line
`timescale 1ns/1ps
module bus_host_model (
    // Clock
    input wire logic clk_in,
    // Bus
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_low_out = !b;
        tick(3);
        scl_out = 1'b1;
        tick(3);
        r = sda_line_in;
        scl_out = 1'b0;
    endtask
    task automatic cond(input logic rise);
        tick(2);
        sda_low_out = rise;
        tick(3);
        scl_out = 1'b1;
        tick(12);
        sda_low_out = !rise;
        tick(12);
        scl_out = rise;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic recover;
        logic r = 1'b0;
        scl_out = 1'b0;
        for (int i = 0; i < 9 && !r; i++) bit_io(1'b1, r);
        cond(1'b0);
    endtask
endmodule

//--- tb.sv
// Self-checking bench for the two-wire framing block
`timescale 1ns/1ps
module tb;
    import eeprom_bus_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, rdy = 1'b1, en = 1'b1;
    wr_grade_t grade = GRADE_FAST;
    logic scl, sda_low, sda_out, sda_oe, vld, start_p, stop_p, ovf, ack;
    rx_word_t w;
    bus_status_t st;
    rx_word_t got[$];
    int n_fail = 0, n_tests = 0, n_start = 0, n_stop = 0, n_ovf = 0;
    wire sda_line = !(sda_low || (sda_oe && !sda_out));
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (start_p === 1'b1) n_start++;
        if (stop_p === 1'b1) n_stop++;
        if (ovf === 1'b1) n_ovf++;
        if (vld === 1'b1 && rdy === 1'b1) got.push_back(w);
    end
    eeprom_bus_framing dut (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(en), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe), .grade_in(grade),
        .word_valid_out(vld), .word_out(w), .word_ready_in(rdy), .status_out(st),
        .start_seen_out(start_p), .stop_seen_out(stop_p), .overflow_out(ovf));
    bus_host_model h (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(sda_low));
    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic test_done;
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic do_reset;
        resetn_in = 1'b0;
        h.tick(20);
        resetn_in = 1'b1;
    endtask
    task automatic t_idle;
        do_reset();
        check(st.standby === 1'b1 && sda_oe === 1'b0 && n_start == 0, "reset state");
        h.recover();
        h.tick(12);
        check(n_start == 1 && st.in_frame === 1'b1, "recovery");
    endtask
    task automatic t_read;
        h.cond(1'b0);
        h.send_byte(8'hA1, ack);
        h.tick(8);
        check(ack === 1'b0 && got.size() == 1 && got.pop_front() === {1'b1, 8'hA1}, "read address");
        h.send_byte(8'h5A, ack);
        h.cond(1'b1);
        h.tick(12);
        check(ack === 1'b1 && got.size() == 0 && n_stop == 1 && st.standby === 1'b1, "read end");
    endtask
    task automatic t_fill;
        int nak = 0;
        rdy = 1'b0;
        h.cond(1'b0);
        for (int i = 0; i < 33; i++) begin
            h.send_byte(i == 0 ? 8'hA0 : 8'(i), ack);
            nak += (ack !== 1'b0);
        end
        check(nak == 0 && n_ovf == 1, "fill");
        rdy = 1'b1;
        h.tick(80);
        check(got.size() == 32 && got[0] === {1'b1, 8'hA0}, "drain");
        for (int i = 1; i < 32; i++) check(got[i] === {1'b0, 8'(i)}, "word");
        h.cond(1'b1);
        h.tick(12);
        check(st.write_busy === 1'b1, "no write cycle");
    endtask
    task automatic t_busy;
        h.cond(1'b0);
        h.send_byte(8'hA0, ack);
        h.cond(1'b1);
        h.tick(1000);
        check(ack === 1'b1 && n_start == 3 && n_stop == 2 && st.write_busy === 1'b1, "busy");
        do_reset();
        check(st.standby === 1'b1 && st.write_busy === 1'b0, "second reset");
    endtask
    task automatic t_freeze;
        en = 1'b0;
        h.cond(1'b0);
        h.tick(12);
        check(n_start == 3 && st.standby === 1'b1 && st.in_frame === 1'b0, "frozen");
        en = 1'b1;
        h.cond(1'b1);
        h.cond(1'b0);
        h.tick(12);
        check(n_stop == 3 && n_start == 4 && st.in_frame === 1'b1, "thawed");
    endtask
    initial begin
        t_idle();
        t_read();
        t_fill();
        t_busy();
        t_freeze();
        test_done();
    end
endmodule
